// ---- include/sarseq_regs.svh ----
`ifndef SARSEQ_REGS_SVH
`define SARSEQ_REGS_SVH

// register byte offsets
`define SARSEQ_OFS_RESULT 4'h0
`define SARSEQ_OFS_STATUS 4'h4
`define SARSEQ_OFS_CONTROL 4'h8
`define SARSEQ_OFS_DELAY 4'hC

// control register fields
`define SARSEQ_CTRL_PEND_BIT 6
`define SARSEQ_CTRL_IEN_BIT 5
`define SARSEQ_CTRL_PWR_BIT 3
`define SARSEQ_CTRL_CHAN_MSB 2
`define SARSEQ_CTRL_CHAN_LSB 0

// status register fields
`define SARSEQ_STAT_BUSY_BIT 0

// field widths and reset values
`define SARSEQ_RESULT_W 10
`define SARSEQ_DELAY_W 6
`define SARSEQ_CNT_W 7
`define SARSEQ_RESULT_RST 10'h000
`define SARSEQ_DELAY_RST 6'h00
`define SARSEQ_CHAN_RST 3'h0
`define SARSEQ_CNT_RST 7'h00

// extra converter clock periods between power-up and start
`define SARSEQ_PU_EXTRA 7'h02

`endif

// ---- include/sarseq_pkg.sv ----
package sarseq_pkg;

    // sequencer states, one-hot
    typedef enum logic [4:0] {
        SARSEQ_OFF = 5'h01,
        SARSEQ_WAIT = 5'h02,
        SARSEQ_START = 5'h04,
        SARSEQ_CONV = 5'h08,
        SARSEQ_DONE = 5'h10
    } sarseq_state_type;

    // software-owned control fields
    typedef struct packed {
        logic int_pending;
        logic int_enable;
        logic power_up;
        logic [2:0] input_channel_select;
    } sarseq_ctrl_type;

    // apb request as seen by the slave
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [3:0] paddr;
        logic [31:0] pwdata;
    } sarseq_apb_req_type;

endpackage : sarseq_pkg

// ---- src/sarseq_top.sv ----
`timescale 1ns/1ps
// What this block does
// - start only on one converter clock edge
// - capture result on rising end-of-conversion
// - result register: 10 bits, upper zero
// - status bit 0 shows conversion busy
// - pending flag set when conversion ends
// - writing 0 clears pending flag
// - control bit 3 powers converter up
// - start comes delay plus two periods later
// - control bits 2:0 pick the input
// - delay register six bits, reset zero
// - control bit 5 enables the interrupt
`include "sarseq_regs.svh"

module sarseq_top
    import sarseq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [3:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic converter_clock_input,
    input wire logic adc_eoc,
    input wire logic [9:0] adc_dout,
    output logic adc_start,
    output logic adc_power_up,
    output logic [2:0] input_channel_select,
    output logic adc_irq
);

    logic [1:0] rst_sync_reg;
    logic rst_sync_n;
    logic [1:0] clk_sync_reg;
    logic [1:0] eoc_sync_reg;
    logic [9:0] dout_meta_reg;
    logic [9:0] dout_sync_reg;
    logic clk_prev_reg;
    logic eoc_prev_reg;
    logic conv_rise;
    logic eoc_rise;
    sarseq_apb_req_type req;
    sarseq_ctrl_type ctrl_reg, ctrl_next;
    sarseq_state_type state_reg, state_next;
    logic [`SARSEQ_DELAY_W-1:0] delay_reg, delay_next;
    logic [`SARSEQ_CNT_W-1:0] cnt_reg, cnt_next;
    logic [`SARSEQ_RESULT_W-1:0] result_reg, result_next;
    logic start_reg, start_next;
    logic [31:0] prdata_reg, prdata_next;
    logic busy;
    logic mapped;
    logic wr_ctrl;
    logic [`SARSEQ_CNT_W-1:0] start_count;

    // reset release through two flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_sync_reg[1];

    // pin synchronisers and edge history
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            clk_sync_reg <= 2'h0;
            eoc_sync_reg <= 2'h0;
            dout_meta_reg <= 10'h000;
            dout_sync_reg <= 10'h000;
            clk_prev_reg <= 1'b0;
            eoc_prev_reg <= 1'b0;
        end else begin
            clk_sync_reg <= {clk_sync_reg[0], converter_clock_input};
            eoc_sync_reg <= {eoc_sync_reg[0], adc_eoc};
            dout_meta_reg <= adc_dout;
            dout_sync_reg <= dout_meta_reg;
            clk_prev_reg <= clk_sync_reg[1];
            eoc_prev_reg <= eoc_sync_reg[1];
        end
    end

    // edge detectors look at the second stage only
    assign conv_rise = clk_sync_reg[1] & ~clk_prev_reg;
    assign eoc_rise = eoc_sync_reg[1] & ~eoc_prev_reg;

    // bus decode
    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
    assign mapped = (req.paddr == `SARSEQ_OFS_RESULT) || (req.paddr == `SARSEQ_OFS_STATUS) ||
                    (req.paddr == `SARSEQ_OFS_CONTROL) || (req.paddr == `SARSEQ_OFS_DELAY);
    assign wr_ctrl = req.psel && req.penable && req.pwrite && (req.paddr == `SARSEQ_OFS_CONTROL);
    assign busy = (state_reg == SARSEQ_START) || (state_reg == SARSEQ_CONV);
    assign start_count = {1'b0, delay_reg} + `SARSEQ_PU_EXTRA - 7'h01;

    // next state of registers and sequencer
    always_comb begin
        ctrl_next = ctrl_reg;
        delay_next = delay_reg;
        state_next = state_reg;
        cnt_next = cnt_reg;
        result_next = result_reg;
        start_next = start_reg;
        prdata_next = prdata_reg;
        // register writes in the access phase
        if (req.psel && req.penable && req.pwrite) begin
            if (req.paddr == `SARSEQ_OFS_CONTROL) begin
                ctrl_next.int_enable = req.pwdata[`SARSEQ_CTRL_IEN_BIT];
                ctrl_next.power_up = req.pwdata[`SARSEQ_CTRL_PWR_BIT];
                ctrl_next.input_channel_select =
                    req.pwdata[`SARSEQ_CTRL_CHAN_MSB:`SARSEQ_CTRL_CHAN_LSB];
                if (!req.pwdata[`SARSEQ_CTRL_PEND_BIT]) begin
                    ctrl_next.int_pending = 1'b0;
                end
            end else if (req.paddr == `SARSEQ_OFS_DELAY) begin
                delay_next = req.pwdata[`SARSEQ_DELAY_W-1:0];
            end
        end
        // sequencer, held off while powered down
        if (!ctrl_reg.power_up) begin
            state_next = SARSEQ_OFF;
            start_next = 1'b0;
            cnt_next = `SARSEQ_CNT_RST;
        end else begin
            unique case (state_reg)
                SARSEQ_OFF: begin
                    state_next = SARSEQ_WAIT;
                    cnt_next = conv_rise ? 7'h01 : `SARSEQ_CNT_RST;
                end
                SARSEQ_WAIT: begin
                    if (conv_rise) begin
                        if (cnt_reg == start_count) begin
                            start_next = 1'b1;
                            state_next = SARSEQ_START;
                        end else begin
                            cnt_next = cnt_reg + 7'h01;
                        end
                    end
                end
                SARSEQ_START, SARSEQ_CONV: begin
                    if (conv_rise) begin
                        start_next = 1'b0;
                    end
                    if (state_reg == SARSEQ_START && conv_rise) begin
                        state_next = SARSEQ_CONV;
                    end
                    if (eoc_rise) begin
                        result_next = dout_sync_reg;
                        ctrl_next.int_pending = 1'b1;
                        state_next = SARSEQ_DONE;
                    end
                end
                SARSEQ_DONE: begin
                    start_next = 1'b0;
                end
            endcase
        end
        // read data prepared in the setup phase
        if (req.psel && !req.penable && !req.pwrite) begin
            prdata_next = 32'h0000_0000;
            if (req.paddr == `SARSEQ_OFS_RESULT) begin
                prdata_next[`SARSEQ_RESULT_W-1:0] = result_reg;
            end else if (req.paddr == `SARSEQ_OFS_STATUS) begin
                prdata_next[`SARSEQ_STAT_BUSY_BIT] = busy;
            end else if (req.paddr == `SARSEQ_OFS_CONTROL) begin
                prdata_next[`SARSEQ_CTRL_PEND_BIT] = ctrl_reg.int_pending;
                prdata_next[`SARSEQ_CTRL_IEN_BIT] = ctrl_reg.int_enable;
                prdata_next[`SARSEQ_CTRL_PWR_BIT] = ctrl_reg.power_up;
                prdata_next[`SARSEQ_CTRL_CHAN_MSB:`SARSEQ_CTRL_CHAN_LSB] =
                    ctrl_reg.input_channel_select;
            end else if (req.paddr == `SARSEQ_OFS_DELAY) begin
                prdata_next[`SARSEQ_DELAY_W-1:0] = delay_reg;
            end
        end
    end

    // register stage
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl_reg <= '{int_pending: 1'b0, int_enable: 1'b0, power_up: 1'b0,
                          input_channel_select: `SARSEQ_CHAN_RST};
            delay_reg <= `SARSEQ_DELAY_RST;
            state_reg <= SARSEQ_OFF;
            cnt_reg <= `SARSEQ_CNT_RST;
            result_reg <= `SARSEQ_RESULT_RST;
            start_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            ctrl_reg <= ctrl_next;
            delay_reg <= delay_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            result_reg <= result_next;
            start_reg <= start_next;
            prdata_reg <= prdata_next;
        end
    end

    // outputs
    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = req.psel && req.penable && !mapped;
    assign adc_start = start_reg;
    assign adc_power_up = ctrl_reg.power_up;
    assign input_channel_select = ctrl_reg.input_channel_select;
    assign adc_irq = ctrl_reg.int_pending && ctrl_reg.int_enable;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_sync_n);

    start_edge_a: assert property (
        $rose(adc_start) |-> $past(conv_rise) && !$past(busy))
        else $error("start rose without converter clock edge");
    start_single_a: assert property (
        adc_start && conv_rise && ctrl_reg.power_up |=> !adc_start)
        else $error("start held past one converter period");
    eoc_capture_a: assert property (
        eoc_rise && busy && ctrl_reg.power_up |=> result_reg == $past(dout_sync_reg))
        else $error("result not captured at end of conversion");
    result_read_a: assert property (
        psel && !penable && !pwrite && paddr == `SARSEQ_OFS_RESULT
        |=> prdata == {22'h000000, $past(result_reg)})
        else $error("result read wrong");
    status_read_a: assert property (
        psel && !penable && !pwrite && paddr == `SARSEQ_OFS_STATUS
        |=> prdata == {31'h00000000, $past(busy)})
        else $error("status read wrong");
    pend_set_a: assert property (
        eoc_rise && busy && ctrl_reg.power_up |=> ctrl_reg.int_pending)
        else $error("pending flag not set");
    pend_clear_a: assert property (
        wr_ctrl && !pwdata[`SARSEQ_CTRL_PEND_BIT] && !(eoc_rise && busy)
        |=> !ctrl_reg.int_pending)
        else $error("pending flag not cleared");
    power_off_a: assert property (
        !adc_power_up |=> state_reg == SARSEQ_OFF && !adc_start)
        else $error("sequencer active while powered down");
    delay_count_a: assert property (
        $rose(adc_start) |-> $past(cnt_reg) + 7'h01 == {1'b0, delay_reg} + `SARSEQ_PU_EXTRA)
        else $error("start delay wrong");
    chan_out_a: assert property (
        wr_ctrl |=> input_channel_select
        == $past(pwdata[`SARSEQ_CTRL_CHAN_MSB:`SARSEQ_CTRL_CHAN_LSB]))
        else $error("channel select not applied");
    delay_read_a: assert property (
        psel && !penable && !pwrite && paddr == `SARSEQ_OFS_DELAY
        |=> prdata == {26'h0000000, $past(delay_reg)})
        else $error("delay read wrong");
    // an enabled interrupt must follow the end of a conversion
    irq_out_a: assert property (
        eoc_rise && busy && ctrl_reg.power_up && ctrl_reg.int_enable
        && !(wr_ctrl && !pwdata[`SARSEQ_CTRL_IEN_BIT]) |=> adc_irq)
        else $error("interrupt output wrong");
    busy_set_a: assert property (
        $rose(busy) |-> $rose(adc_start))
        else $error("busy rose without start");

endmodule : sarseq_top

// ---- sim/sarseq_conv_model.sv ----
`timescale 1ns/1ps
module sarseq_conv_model (
    input wire logic conv_clk,
    input wire logic power_up,
    input wire logic start,
    input wire logic [9:0] sample,
    output logic eoc,
    output logic [9:0] dout
);
    logic [2:0] step;
    initial begin
        eoc = 1'b0;
        dout = 10'h3FF;
        step = 3'h0;
    end
    // one conversion per start: data at step 3, end flag at step 4, parked at 6
    always @(posedge conv_clk) begin
        if (!power_up) begin
            step <= 3'h0;
            eoc <= 1'b0;
        end else if (step == 3'h0) begin
            if (start) step <= 3'h1;
        end else if (step != 3'h6) begin
            step <= step + 3'h1;
            if (step == 3'h3) dout <= sample;
            if (step == 3'h4) eoc <= 1'b1;
            if (step == 3'h5) eoc <= 1'b0;
            if (step == 3'h5) dout <= ~dout; // stale data no longer holds
        end
    end
endmodule : sarseq_conv_model

// ---- sim/sar_adc_sequencer_tb.sv ----
`timescale 1ns/1ps
`include "sarseq_regs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module sar_adc_sequencer_tb;
    import sarseq_pkg::*;
    logic clk_sys, rst_n, psel, penable, pwrite, conv_clk, eoc, start, pwr, irq, perr, rdy;
    logic [3:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [9:0] dout, sample;
    logic [2:0] chan;
    logic rd_err, rd_rdy;
    int miscompares = 0, checks_done = 0, edges = 0;
    sarseq_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(rdy),
        .pslverr(perr), .converter_clock_input(conv_clk), .adc_eoc(eoc), .adc_dout(dout),
        .adc_start(start), .adc_power_up(pwr), .input_channel_select(chan), .adc_irq(irq));
    sarseq_conv_model u_conv (.conv_clk(conv_clk), .power_up(pwr), .start(start),
        .sample(sample), .eoc(eoc), .dout(dout));
    // system clock and an unrelated converter clock of 600 ns
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        conv_clk = 1'b0;
        #17;
        forever #300 conv_clk = ~conv_clk;
    end
    always @(posedge conv_clk) edges++;
    task automatic apb_wr(input logic [3:0] a, input logic [31:0] d);
        @(negedge clk_sys);
        psel = 1'b1; pwrite = 1'b1; paddr = a; pwdata = d;
        @(negedge clk_sys);
        penable = 1'b1;
        @(negedge clk_sys);
        psel = 1'b0; penable = 1'b0;
    endtask : apb_wr
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] d;
        @(negedge clk_sys);
        psel = 1'b1; pwrite = 1'b0; paddr = a;
        @(negedge clk_sys);
        penable = 1'b1;
        @(posedge clk_sys);
        d = prdata;
        rd_err = perr;
        rd_rdy = rdy;
        @(negedge clk_sys);
        psel = 1'b0; penable = 1'b0;
        `CHK(d, exp)
    endtask : rd_chk
    // reset values, field widths, read-only places and every channel code
    task automatic t_regs();
        rd_chk(`SARSEQ_OFS_RESULT, 32'h0);
        `CHK({rd_rdy, rd_err}, 2'b10)
        rd_chk(`SARSEQ_OFS_STATUS, 32'h0);
        rd_chk(`SARSEQ_OFS_CONTROL, 32'h0);
        rd_chk(`SARSEQ_OFS_DELAY, 32'h0);
        apb_wr(`SARSEQ_OFS_DELAY, 32'hFFFF_FFFF);
        rd_chk(`SARSEQ_OFS_DELAY, 32'h3F);
        apb_wr(`SARSEQ_OFS_RESULT, 32'hFFFF_FFFF);
        rd_chk(`SARSEQ_OFS_RESULT, 32'h0);
        apb_wr(`SARSEQ_OFS_CONTROL, 32'hFFFF_FFF7);
        rd_chk(`SARSEQ_OFS_CONTROL, 32'h27);
        `CHK(pwr, 1'b0)
        for (int c = 0; c < 8; c++) begin
            apb_wr(`SARSEQ_OFS_CONTROL, 32'(c));
            `CHK(chan, 3'(c))
        end
        rd_chk(4'h2, 32'h0); // unmapped place reads zero
        `CHK({rd_rdy, rd_err}, 2'b11) // unmapped place flags an error
    endtask : t_regs
    // one single-sample conversion with a given delay, result and interrupt enable
    task automatic t_conv(input logic [5:0] dly, input logic [9:0] val, input logic ien);
        int e0;
        sample = val;
        apb_wr(`SARSEQ_OFS_DELAY, {26'h0, dly});
        apb_wr(`SARSEQ_OFS_CONTROL, {26'h0, ien, 5'h2}); // input picked while off
        @(negedge conv_clk);
        apb_wr(`SARSEQ_OFS_CONTROL, {26'h0, ien, 5'hA});
        e0 = edges;
        `CHK(pwr, 1'b1)
        for (int i = 0; i < 3000 && start !== 1'b1; i++) @(negedge clk_sys);
        `CHK(edges - e0, int'(dly) + 2)
        rd_chk(`SARSEQ_OFS_STATUS, 32'h1);
        e0 = edges;
        for (int i = 0; i < 100 && start !== 1'b0; i++) @(negedge clk_sys);
        `CHK(edges - e0, 1)
        repeat (7) @(negedge conv_clk);
        `CHK(start, 1'b0)
        rd_chk(`SARSEQ_OFS_RESULT, {22'h0, val});
        rd_chk(`SARSEQ_OFS_STATUS, 32'h0);
        rd_chk(`SARSEQ_OFS_CONTROL, {25'h0, 1'b1, ien, 5'hA});
        `CHK(irq, ien)
        apb_wr(`SARSEQ_OFS_CONTROL, {26'h0, ien, 5'hA});
        rd_chk(`SARSEQ_OFS_CONTROL, {26'h0, ien, 5'hA});
        `CHK(irq, 1'b0)
        apb_wr(`SARSEQ_OFS_CONTROL, {26'h0, ien, 5'h2});
        `CHK(pwr, 1'b0)
    endtask : t_conv
    task automatic end_sim();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // watchdog: tests need about a thousand system clock cycles, limit is 10000
    initial begin
        #500000;
        miscompares++;
        end_sim();
    end
    initial begin
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 4'h0; pwdata = 32'h0; sample = 10'h0;
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        t_regs();
        t_conv(6'h00, 10'h2A5, 1'b1);
        t_conv(6'h3F, 10'h15A, 1'b0);
        end_sim();
    end
endmodule : sar_adc_sequencer_tb
